// >>> logic/fsk_deviation_rx_sync_timeout.sv
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`include "fsk_dev_regs.svh"

module fsk_deviation_rx_sync_timeout
	import fsk_dev_pkg::*;
#(
	parameter int REF_DIV = `REF_DIV_CYC
)
(
	// Clock and reset
	input  wire logic        I_CLK,
	input  wire logic        I_RESET_N,
	// APB slave
	input  wire logic        I_PSEL,
	input  wire logic        I_PENABLE,
	input  wire logic        I_PWRITE,
	input  wire logic [17:0] I_PADDR,
	input  wire logic [31:0] I_PWDATA,
	output logic      [31:0] O_PRDATA,
	output logic             O_PREADY,
	output logic             O_PSLVERR,
	// Modem side
	input  wire logic        I_TX_ACTIVE,
	input  wire logic        I_TX_BIT,
	input  wire logic        I_RX_ACTIVE,
	input  wire logic        I_SYNC_FOUND,
	input  wire logic        I_PQT_REACHED,
	input  wire logic        I_CARRIER_SENSE,
	// Modulation controls
	output logic      [11:0] O_TX_FREQ_OFFSET,
	output logic      [3:0]  O_MSK_PHASE_EIGHTHS,
	output logic             O_MSK_PHASE_NEG,
	output logic      [10:0] O_RX_EXP_DEV,
	// Receive timeout results
	output logic             O_RX_SEARCHING,
	output logic             O_RX_STAY,
	output logic             O_RX_TIMEOUT_EXP,
	output logic             O_RX_TERMINATE
);

	// Deviation magnitude in units of fref / 2^17
	function automatic logic [10:0] dev_mag(input dev_field_t mant, input dev_field_t expo);
		return (`DEV_BASE + 11'(mant)) << expo;
	endfunction

	function automatic logic addr_hit(input logic [17:0] addr, input logic [15:0] idx);
		return addr == {idx, 2'b00};
	endfunction

	dev_field_t  dev_exp_r;
	dev_field_t  dev_mant_r;
	logic [4:0]  rtc_r;
	logic [2:0]  ctl_r;
	logic [15:0] evp_r;
	logic [7:0]  div_r;
	logic        tick_r;

	// Bus decode
	wire         setup    = I_PSEL & ~I_PENABLE;
	wire         wr       = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE;
	wire         hit_fds  = addr_hit(I_PADDR, `FDS_IDX);
	wire         hit_rtc  = addr_hit(I_PADDR, `RTC_IDX);
	wire         hit_ctl  = addr_hit(I_PADDR, `CTL_IDX);
	wire         hit_evp  = addr_hit(I_PADDR, `EVP_IDX);
	wire         hit_sta  = addr_hit(I_PADDR, `STA_IDX);
	wire         hit_any  = hit_fds | hit_rtc | hit_ctl | hit_evp | hit_sta;

	// Field views
	wire         msk_mode  = ctl_r[`CTL_MSK_BIT];
	wire  [1:0]  wake_res  = ctl_r[`CTL_RES_MSB:`CTL_RES_LSB];
	wire  [2:0]  tmo_code  = rtc_r[`RTC_CODE_MSB:`RTC_CODE_LSB];
	wire         tmo_qual  = rtc_r[`RTC_QUAL_BIT];
	wire         cs_term   = rtc_r[`RTC_CS_BIT];
	wire  [10:0] mag       = dev_mag(dev_mant_r, dev_exp_r);
	wire  [11:0] mag_s     = {1'b0, mag};
	wire         fsk_tx    = I_TX_ACTIVE & ~msk_mode;
	wire         msk_tx    = I_TX_ACTIVE & msk_mode;
	wire         fsk_rx    = I_RX_ACTIVE & ~msk_mode;

	// Read mux; unused bits above each field read zero
	wire  [31:0] rd_fds   = {25'h0, dev_exp_r, 1'b0, dev_mant_r};
	wire  [31:0] rd_rtc   = {27'h0, rtc_r};
	wire  [31:0] rd_ctl   = {29'h0, ctl_r};
	wire  [31:0] rd_evp   = {16'h0, evp_r};
	wire  [31:0] rd_sta   = {28'h0, O_RX_TERMINATE, O_RX_TIMEOUT_EXP, O_RX_STAY,
		O_RX_SEARCHING};
	wire  [31:0] rd_mux   = hit_fds ? rd_fds :
		hit_rtc ? rd_rtc :
		hit_ctl ? rd_ctl :
		hit_evp ? rd_evp :
		hit_sta ? rd_sta : 32'h0;

	// Modulation selections
	wire  [11:0] tx_off_nxt = !fsk_tx ? 12'h000 : (I_TX_BIT ? mag_s : 12'(-mag_s));
	wire  [3:0]  eighths    = {1'b0, dev_mant_r} + 4'h1;
	wire  [10:0] rx_dev_nxt = fsk_rx ? mag : 11'h000;

	// Zero-wait slave: data and ready registered in setup, used in access
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			O_PRDATA  <= 32'h0;
			O_PREADY  <= 1'b0;
			O_PSLVERR <= 1'b0;
		end else begin
			O_PREADY  <= setup;
			O_PSLVERR <= setup & ~hit_any;
			if (setup)
				O_PRDATA <= rd_mux;
		end
	end

	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			dev_exp_r  <= `FDS_EXP_RST;
			dev_mant_r <= `FDS_MANT_RST;
		end else if (wr && hit_fds) begin
			dev_exp_r  <= I_PWDATA[`FDS_EXP_MSB:`FDS_EXP_LSB];
			dev_mant_r <= I_PWDATA[`FDS_MANT_MSB:`FDS_MANT_LSB];
		end
	end

	// Upper bits of the write data are dropped
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N)
			rtc_r <= `RTC_RST;
		else if (wr && hit_rtc)
			rtc_r <= I_PWDATA[4:0];
	end

	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			ctl_r <= `CTL_RST;
			evp_r <= `EVP_RST;
		end else begin
			if (wr && hit_ctl)
				ctl_r <= I_PWDATA[2:0];
			if (wr && hit_evp)
				evp_r <= I_PWDATA[15:0];
		end
	end

	// Reference-period tick; integer divide, so timeouts run slightly short
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			div_r  <= 8'h00;
			tick_r <= 1'b0;
		end else begin
			tick_r <= (div_r == 8'(REF_DIV - 1));
			div_r  <= (div_r == 8'(REF_DIV - 1)) ? 8'h00 : div_r + 8'h01;
		end
	end

	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			O_TX_FREQ_OFFSET    <= 12'h000;
			O_MSK_PHASE_EIGHTHS <= 4'h0;
			O_MSK_PHASE_NEG     <= 1'b0;
			O_RX_EXP_DEV        <= 11'h000;
		end else begin
			O_TX_FREQ_OFFSET    <= tx_off_nxt;
			O_MSK_PHASE_EIGHTHS <= msk_tx ? eighths : 4'h0;
			O_MSK_PHASE_NEG     <= msk_tx & I_TX_BIT;
			O_RX_EXP_DEV        <= rx_dev_nxt;
		end
	end

	rx_timeout_timer u_timer (
		.i_clk           (I_CLK),
		.i_reset_n       (I_RESET_N),
		.i_tick          (tick_r),
		.i_rx_active     (I_RX_ACTIVE),
		.i_sync_found    (I_SYNC_FOUND),
		.i_pqt_reached   (I_PQT_REACHED),
		.i_carrier_sense (I_CARRIER_SENSE),
		.i_timeout_code  (tmo_code),
		.i_qual          (tmo_qual),
		.i_cs_term       (cs_term),
		.i_wake_res      (wake_res),
		.i_event_period  (evp_r),
		.o_searching     (O_RX_SEARCHING),
		.o_stay          (O_RX_STAY),
		.o_expired       (O_RX_TIMEOUT_EXP),
		.o_terminate     (O_RX_TERMINATE)
	);

	property p_tx_one_positive;
		@(posedge I_CLK) disable iff (!I_RESET_N)
		fsk_tx && I_TX_BIT |=> O_TX_FREQ_OFFSET == {1'b0, $past(mag)};
	endproperty
	a_tx_one_positive: assert property (p_tx_one_positive)
		else $error("one bit not shifted up by deviation");

	property p_tx_zero_negative;
		@(posedge I_CLK) disable iff (!I_RESET_N)
		fsk_tx && !I_TX_BIT |=> O_TX_FREQ_OFFSET + {1'b0, $past(mag)} == 12'h000;
	endproperty
	a_tx_zero_negative: assert property (p_tx_zero_negative)
		else $error("zero bit not shifted down by deviation");

	property p_msk_fraction;
		@(posedge I_CLK) disable iff (!I_RESET_N)
		msk_tx |=> O_MSK_PHASE_EIGHTHS == {1'b0, $past(dev_mant_r)} + 4'h1
			&& O_MSK_PHASE_NEG == $past(I_TX_BIT) && O_TX_FREQ_OFFSET == 12'h000;
	endproperty
	a_msk_fraction: assert property (p_msk_fraction)
		else $error("wrong phase-change fraction in MSK");

	property p_rx_expected;
		@(posedge I_CLK) disable iff (!I_RESET_N)
		fsk_rx |=> O_RX_EXP_DEV == $past(mag);
	endproperty
	a_rx_expected: assert property (p_rx_expected)
		else $error("expected deviation not presented");

	property p_rx_msk_ignored;
		@(posedge I_CLK) disable iff (!I_RESET_N)
		I_RX_ACTIVE && msk_mode |=> O_RX_EXP_DEV == 11'h000;
	endproperty
	a_rx_msk_ignored: assert property (p_rx_msk_ignored)
		else $error("deviation leaked into MSK receive");

	property p_rtc_upper_zero;
		@(posedge I_CLK) disable iff (!I_RESET_N)
		setup && hit_rtc |=> O_PRDATA[31:5] == 27'h0 && O_PREADY;
	endproperty
	a_rtc_upper_zero: assert property (p_rtc_upper_zero)
		else $error("unused timeout bits read nonzero");

	property p_exp_readback;
		@(posedge I_CLK) disable iff (!I_RESET_N)
		setup && hit_fds |=> O_PRDATA[6:4] == $past(dev_exp_r) && O_PRDATA[7] == 1'b0;
	endproperty
	a_exp_readback: assert property (p_exp_readback)
		else $error("deviation exponent readback wrong");

	property p_ready_one_cycle;
		@(posedge I_CLK) disable iff (!I_RESET_N)
		O_PREADY |=> !O_PREADY;
	endproperty
	a_ready_one_cycle: assert property (p_ready_one_cycle)
		else $error("ready held longer than one cycle");

	property p_unmapped_err;
		@(posedge I_CLK) disable iff (!I_RESET_N)
		setup && !hit_any |=> O_PSLVERR && O_PRDATA == 32'h0;
	endproperty
	a_unmapped_err: assert property (p_unmapped_err)
		else $error("unmapped access not refused");

	property p_rtc_write;
		@(posedge I_CLK) disable iff (!I_RESET_N)
		wr && hit_rtc |=> {27'h0, rtc_r} == ($past(I_PWDATA) & 32'h0000001F);
	endproperty
	a_rtc_write: assert property (p_rtc_write)
		else $error("timeout register write not masked to its fields");

	property p_rtc_hold;
		@(posedge I_CLK) disable iff (!I_RESET_N)
		!(wr && hit_rtc) |=> $stable(rtc_r);
	endproperty
	a_rtc_hold: assert property (p_rtc_hold)
		else $error("timeout register changed without a write");

	property p_fds_write;
		@(posedge I_CLK) disable iff (!I_RESET_N)
		wr && hit_fds |=> {25'h0, dev_exp_r, 1'b0, dev_mant_r} == ($past(I_PWDATA) & 32'h00000077);
	endproperty
	a_fds_write: assert property (p_fds_write)
		else $error("deviation register write wrong");

	property p_fds_hold;
		@(posedge I_CLK) disable iff (!I_RESET_N)
		!(wr && hit_fds) |=> $stable(dev_exp_r) && $stable(dev_mant_r);
	endproperty
	a_fds_hold: assert property (p_fds_hold)
		else $error("deviation register changed without a write");

	property p_idle_offset;
		@(posedge I_CLK) disable iff (!I_RESET_N)
		!I_TX_ACTIVE |=> O_TX_FREQ_OFFSET == 12'h000 && O_MSK_PHASE_EIGHTHS == 4'h0;
	endproperty
	a_idle_offset: assert property (p_idle_offset)
		else $error("modulation shown while not transmitting");

	property p_rx_idle_zero;
		@(posedge I_CLK) disable iff (!I_RESET_N)
		!I_RX_ACTIVE |=> O_RX_EXP_DEV == 11'h000;
	endproperty
	a_rx_idle_zero: assert property (p_rx_idle_zero)
		else $error("expected deviation shown while not receiving");

	c_fsk_tx:  cover property (@(posedge I_CLK) disable iff (!I_RESET_N) fsk_tx && I_TX_BIT);
	c_msk_tx:  cover property (@(posedge I_CLK) disable iff (!I_RESET_N) msk_tx);
	c_rtc_wr:  cover property (@(posedge I_CLK) disable iff (!I_RESET_N) wr && hit_rtc);

endmodule

// >>> logic/fsk_dev_regs.svh
`ifndef FSK_DEV_REGS_SVH
`define FSK_DEV_REGS_SVH

// Register indices; byte address is four times the index
`define FDS_IDX          16'hDF11
`define RTC_IDX          16'hDF12
`define CTL_IDX          16'hDF40
`define EVP_IDX          16'hDF41
`define STA_IDX          16'hDF42

// Deviation register fields and reset
`define FDS_EXP_MSB      6
`define FDS_EXP_LSB      4
`define FDS_MANT_MSB     2
`define FDS_MANT_LSB     0
`define FDS_EXP_RST      3'h4
`define FDS_MANT_RST     3'h7

// Receive-timeout register fields and reset
`define RTC_CS_BIT       4
`define RTC_QUAL_BIT     3
`define RTC_CODE_MSB     2
`define RTC_CODE_LSB     0
`define RTC_RST          5'h07
`define RTC_CODE_NONE    3'h7

// Control register fields and reset, and event-period register reset
`define CTL_MSK_BIT      0
`define CTL_RES_MSB      2
`define CTL_RES_LSB      1
`define CTL_RST          3'h0
`define EVP_RST          16'h0800

// Timing
`define SYS_CLK_MHZ      125
`define REF_CLK_MHZ      26
`define REF_DIV_CYC      ((`SYS_CLK_MHZ) / (`REF_CLK_MHZ))
`define TMO_BASE_NUM     32'd375
`define TMO_BASE_SHIFT   2
`define DEV_BASE         11'h008

`endif

// >>> logic/fsk_dev_pkg.sv
package fsk_dev_pkg;

	typedef enum logic [1:0] {
		TS_IDLE   = 2'b00,
		TS_SEARCH = 2'b01,
		TS_HOLD   = 2'b10,
		TS_DONE   = 2'b11
	} tmo_state_t;

	typedef logic [2:0]  dev_field_t;
	typedef logic [28:0] tmo_count_t;

endpackage

// >>> logic/rx_timeout_timer.sv
`timescale 1ns/1ps
`include "fsk_dev_regs.svh"

module rx_timeout_timer
	import fsk_dev_pkg::*;
(
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_reset_n,
	// Reference tick and radio status
	input  wire logic        i_tick,
	input  wire logic        i_rx_active,
	input  wire logic        i_sync_found,
	input  wire logic        i_pqt_reached,
	input  wire logic        i_carrier_sense,
	// Configuration
	input  wire logic [2:0]  i_timeout_code,
	input  wire logic        i_qual,
	input  wire logic        i_cs_term,
	input  wire logic [1:0]  i_wake_res,
	input  wire logic [15:0] i_event_period,
	// Results
	output logic             o_searching,
	output logic             o_stay,
	output logic             o_expired,
	output logic             o_terminate
);

	// Reference periods: event * 375 * (1 + 4 * res) / 2^(code + 2)
	function automatic tmo_count_t tmo_target(input logic [15:0] ev, input logic [1:0] res,
		input logic [2:0] code);
		logic [31:0] prod;
		prod = 32'(ev) * `TMO_BASE_NUM * (32'd1 + 32'd4 * 32'(res));
		return tmo_count_t'(prod >> (32'(code) + `TMO_BASE_SHIFT));
	endfunction

	tmo_state_t  state_r;
	tmo_state_t  state_nxt;
	tmo_count_t  cnt_r;
	logic        rx_d_r;

	wire         rx_start  = i_rx_active & ~rx_d_r;
	wire tmo_count_t target = tmo_target(i_event_period, i_wake_res, i_timeout_code);
	wire         no_tmo    = (i_timeout_code == `RTC_CODE_NONE);
	// Code 111 blocks expiry even if written while a search is running
	wire         hit       = i_tick & ~no_tmo & (cnt_r >= target);
	wire         stay_cond = i_sync_found | (i_qual & i_pqt_reached);
	wire         cs_drop   = i_tick & i_cs_term & ~i_carrier_sense;
	wire         in_search = (state_r == TS_SEARCH);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			TS_IDLE: begin
				if (rx_start)
					state_nxt = no_tmo ? TS_HOLD : TS_SEARCH;
			end
			TS_SEARCH: begin
				if (hit)
					state_nxt = stay_cond ? TS_HOLD : TS_DONE;
				else if (cs_drop)
					state_nxt = TS_DONE;
			end
			TS_HOLD, TS_DONE: begin
				state_nxt = state_r;
			end
			default: state_nxt = TS_IDLE;
		endcase
		if (!i_rx_active)
			state_nxt = TS_IDLE;
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_r     <= TS_IDLE;
			cnt_r       <= '0;
			rx_d_r      <= 1'b0;
			o_searching <= 1'b0;
			o_stay      <= 1'b0;
			o_expired   <= 1'b0;
			o_terminate <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			rx_d_r      <= i_rx_active;
			cnt_r       <= (in_search && i_tick) ? cnt_r + 29'h1 : (in_search ? cnt_r : '0);
			o_searching <= (state_nxt == TS_SEARCH);
			o_stay      <= (state_nxt == TS_HOLD);
			o_expired   <= in_search & hit & i_rx_active;
			o_terminate <= in_search & i_rx_active & (state_nxt == TS_DONE);
		end
	end

	property p_no_expiry_when_disabled;
		@(posedge i_clk) disable iff (!i_reset_n)
		(in_search || i_rx_active) && no_tmo |=> !o_expired;
	endproperty
	a_no_expiry_when_disabled: assert property (p_no_expiry_when_disabled)
		else $error("timeout expired with timeout disabled");

	property p_expiry_stays;
		@(posedge i_clk) disable iff (!i_reset_n)
		in_search && i_rx_active && hit && stay_cond |=> o_stay && !o_terminate;
	endproperty
	a_expiry_stays: assert property (p_expiry_stays)
		else $error("receive did not stay after qualified expiry");

	property p_expiry_ends;
		@(posedge i_clk) disable iff (!i_reset_n)
		in_search && i_rx_active && hit && !stay_cond |=> o_terminate ##1 !o_terminate;
	endproperty
	a_expiry_ends: assert property (p_expiry_ends)
		else $error("receive not ended by unqualified expiry");

	property p_cs_ends;
		@(posedge i_clk) disable iff (!i_reset_n)
		in_search && i_rx_active && !hit && cs_drop |=> o_terminate && !o_searching;
	endproperty
	a_cs_ends: assert property (p_cs_ends)
		else $error("carrier sense loss did not end receive");

	property p_no_early_expiry;
		@(posedge i_clk) disable iff (!i_reset_n)
		o_expired |-> $past(cnt_r) >= $past(target);
	endproperty
	a_no_early_expiry: assert property (p_no_early_expiry)
		else $error("timeout expired before its count");

	c_expire_stay: cover property (@(posedge i_clk) disable iff (!i_reset_n) o_expired && o_stay);
	c_expire_end:  cover property (@(posedge i_clk) disable iff (!i_reset_n) o_expired && o_terminate);

endmodule

// >>> test/tb.sv
`timescale 1ns/1ps
`include "fsk_dev_regs.svh"

`define CHK(a, e) check(64'(a), 64'(e));

module tb;

	localparam logic [17:0] A_DEV = {`FDS_IDX, 2'b00};
	localparam logic [17:0] A_RTC = {`RTC_IDX, 2'b00};
	localparam logic [17:0] A_CTL = {`CTL_IDX, 2'b00};
	localparam logic [17:0] A_EVP = {`EVP_IDX, 2'b00};
	localparam logic [17:0] A_STA = {`STA_IDX, 2'b00};

	logic        clk;
	logic        rst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [17:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] rd;
	logic        er;
	logic        tx_act;
	logic        tx_bit;
	logic        rx_act;
	logic        sync;
	logic        preamble_quality_threshold;
	logic        cs;
	logic [11:0] tx_off;
	logic [3:0]  eighths;
	logic        neg;
	logic [10:0] exp_dev;
	logic        searching;
	logic        stay;
	logic        expired;
	logic        term;
	int          bad_count;
	int          compares;

	// Divider of 1 keeps the timeout runs short
	fsk_deviation_rx_sync_timeout #(.REF_DIV(1)) dut (
		.I_CLK              (clk),
		.I_RESET_N          (rst_n),
		.I_PSEL             (psel),
		.I_PENABLE          (penable),
		.I_PWRITE           (pwrite),
		.I_PADDR            (paddr),
		.I_PWDATA           (pwdata),
		.O_PRDATA           (prdata),
		.O_PREADY           (pready),
		.O_PSLVERR          (pslverr),
		.I_TX_ACTIVE        (tx_act),
		.I_TX_BIT           (tx_bit),
		.I_RX_ACTIVE        (rx_act),
		.I_SYNC_FOUND       (sync),
		.I_PQT_REACHED      (preamble_quality_threshold),
		.I_CARRIER_SENSE    (cs),
		.O_TX_FREQ_OFFSET   (tx_off),
		.O_MSK_PHASE_EIGHTHS(eighths),
		.O_MSK_PHASE_NEG    (neg),
		.O_RX_EXP_DEV       (exp_dev),
		.O_RX_SEARCHING     (searching),
		.O_RX_STAY          (stay),
		.O_RX_TIMEOUT_EXP   (expired),
		.O_RX_TERMINATE     (term)
	);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic end_sim;
		if (bad_count == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Wide enough to keep the error bit beside a full data word
	task automatic check(input logic [63:0] a, input logic [63:0] e);
		compares++;
		if (a !== e) begin
			bad_count++;
			$display("mismatch t=%0t got=%0h exp=%0h", $time, a, e);
		end
	endtask

	// Request held until ready is seen high at a rising edge
	task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		// Ready, data and error taken at the edge that completes the access
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		`CHK(n, 1)
	endtask

	task automatic settle;
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask

	function automatic logic [10:0] mag(input logic [2:0] m, input logic [2:0] e);
		return (11'h008 + 11'(m)) << e;
	endfunction

	function automatic logic [11:0] foff(input logic [2:0] m, input logic [2:0] e, input logic b);
		return b ? {1'b0, mag(m, e)} : 12'h000 - {1'b0, mag(m, e)};
	endfunction

	// Reference ticks until expiry
	function automatic int tgt(input int ev, input int res, input int code);
		return (ev * 375 * (1 + 4 * res)) >> (code + 2);
	endfunction

	task automatic rx_run(input logic [2:0] code, input logic [1:0] res, input logic [15:0] ev,
		input logic c, input logic q, input logic sy, input logic pq, input logic cl,
		input int lim, output int n, output logic ex, output logic tm, output logic st,
		output logic [31:0] sr);
		apb(1'b1, A_CTL, {29'h0, res, 1'b0});
		apb(1'b1, A_EVP, {16'h0, ev});
		apb(1'b1, A_RTC, {27'h0, c, q, code});
		sync <= sy;
		preamble_quality_threshold  <= pq;
		cs   <= cl;
		@(posedge clk);
		rx_act <= 1'b1;
		ex = 1'b0;
		tm = 1'b0;
		for (n = 0; n < lim; n++) begin
			@(negedge clk);
			if (expired === 1'b1 || term === 1'b1) break;
		end
		ex = expired;
		tm = term;
		st = stay;
		apb(1'b0, A_STA, 32'h0);
		sr = rd;
		@(posedge clk);
		rx_act <= 1'b0;
		settle;
		`CHK({searching, stay, expired, term}, 4'h0)
	endtask

	initial begin
		int         i;
		int         n;
		logic [2:0] m;
		logic [2:0] e;
		logic [2:0] code;
		logic [1:0] res;
		logic [15:0] ev;
		logic       msk;
		logic       b;
		logic       txm;
		logic       sy;
		logic       ex;
		logic       tm;
		logic       st;
		logic [31:0] sr;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{tx_act, tx_bit, rx_act, sync, preamble_quality_threshold, cs} = '0;
		bad_count = 0;
		compares  = 0;
		rst_n     = 1'b0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		void'($urandom(5));
		apb(1'b0, A_DEV, 32'h0);
		`CHK({er, rd}, 33'h000000047)
		apb(1'b0, A_RTC, 32'h0);
		`CHK({er, rd}, 33'h000000007)
		apb(1'b0, A_CTL, 32'h0);
		`CHK(rd, 32'h00000000)
		apb(1'b0, A_EVP, 32'h0);
		`CHK(rd, 32'h00000800)
		apb(1'b1, A_RTC, 32'hFFFFFFE0);
		apb(1'b0, A_RTC, 32'h0);
		`CHK(rd, 32'h00000000)
		apb(1'b1, A_RTC, 32'hFFFFFFFF);
		apb(1'b0, A_RTC, 32'h0);
		`CHK(rd, 32'h0000001F)
		apb(1'b1, A_DEV, 32'hFFFFFF88);
		apb(1'b0, A_DEV, 32'h0);
		`CHK(rd, 32'h00000000)
		apb(1'b1, 18'h00004, 32'hFFFFFFFF);
		`CHK(er, 1'b1)
		apb(1'b0, 18'h00004, 32'h0);
		`CHK({er, rd}, 33'h100000000)
		for (i = 0; i < 24; i++) begin
			m   = (i == 0) ? 3'h7 : (i == 1) ? 3'h0 : 3'($urandom_range(0, 7));
			e   = (i == 0) ? 3'h7 : (i == 1) ? 3'h0 : 3'($urandom_range(0, 7));
			msk = 1'($urandom_range(0, 1));
			b   = 1'($urandom_range(0, 1));
			txm = 1'($urandom_range(0, 1));
			apb(1'b1, A_DEV, {25'h0, e, 1'b0, m});
			apb(1'b1, A_CTL, {31'h0, msk});
			tx_act <= txm;
			rx_act <= ~txm;
			tx_bit <= b;
			settle;
			if (txm) begin
				`CHK(tx_off, msk ? 12'h000 : foff(m, e, b))
				`CHK(eighths, msk ? 4'(m) + 4'h1 : 4'h0)
				`CHK(neg, msk & b)
			end else begin
				`CHK(exp_dev, msk ? 11'h000 : mag(m, e))
			end
		end
		tx_act <= 1'b0;
		rx_act <= 1'b0;
		settle;
		// Mid-run reset must bring back the deviation defaults
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, A_DEV, 32'h0);
		`CHK({er, rd}, 33'h000000047)
		// Every qualifier, sync and preamble combination at expiry
		for (i = 0; i < 8; i++) begin
			code = 3'($urandom_range(0, 6));
			res  = 2'($urandom_range(0, 3));
			ev   = 16'($urandom_range(1, 3));
			sy   = i[0];
			rx_run(code, res, ev, 1'b0, i[1], sy, i[2], 1'b1, 5000, n, ex, tm, st, sr);
			`CHK({ex, st, tm}, {1'b1, sy | (i[1] & i[2]), ~(sy | (i[1] & i[2]))})
			`CHK(sr, {30'h0, sy | (i[1] & i[2]), 1'b0})
			`CHK((n >= tgt(ev, res, code)) && (n <= tgt(ev, res, code) + 4), 1'b1)
		end
		rx_run(3'h0, 2'h3, 16'h0004, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 5000, n, ex, tm, st, sr);
		`CHK({ex, tm, n < 6}, 3'h3)
		`CHK(sr, 32'h00000000)
		rx_run(3'h7, 2'h0, 16'h0001, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 200, n, ex, tm, st, sr);
		`CHK({ex, tm, st}, 3'h1)
		`CHK(sr, 32'h00000002)
		end_sim;
	end

	initial begin
		repeat (90000) @(posedge clk);
		bad_count++;
		end_sim;
	end

endmodule
